// [inc/dscs_map.vh]
`ifndef DSCS_MAP_VH
`define DSCS_MAP_VH

// Register offsets (byte addresses on the plain register port)
`define DSCS_REG_CTRL 8'h00
`define DSCS_REG_FIX1 8'h04
`define DSCS_REG_FIX2 8'h08
`define DSCS_REG_FIX3 8'h0C
`define DSCS_REG_FIX4 8'h10
`define DSCS_REG_FMAX 8'h14
`define DSCS_REG_KEYPAD 8'h18
`define DSCS_REG_STATUS 8'h1C
`define DSCS_REG_SETPOINT 8'h20
`define DSCS_REG_PINS 8'h24
`define DSCS_REG_STEP 8'h28

// Control register fields
`define DSCS_CTRL_MODE_LSB 0
`define DSCS_CTRL_MODE_MSB 1
`define DSCS_CTRL_SEL_LSB 2
`define DSCS_CTRL_SEL_MSB 5
`define DSCS_CTRL_STOP_LSB 6
`define DSCS_CTRL_STOP_MSB 7
`define DSCS_CTRL_RESET 8'h00

// Control modes
`define DSCS_MODE_TERMINAL 2'h0
`define DSCS_MODE_DIG_ONE 2'h1
`define DSCS_MODE_DIG_TWO 2'h2

// Source selector meanings
`define DSCS_SEL_FIX_MAX 4'h0
`define DSCS_SEL_F2_F4 4'h1
`define DSCS_SEL_F4_AI1 4'h2
`define DSCS_SEL_F4_BUS 4'h3
`define DSCS_SEL_F4_DIG 4'h4
`define DSCS_SEL_F4_F2 4'h5
`define DSCS_SEL_F4_REG 4'h6
`define DSCS_SEL_REG_AI1 4'h7
`define DSCS_SEL_REG_F1 4'h8

// Pin positions in the terminal vector
`define DSCS_PIN_RUN 0
`define DSCS_PIN_QSTOP_EN 1
`define DSCS_PIN_DIR 2
`define DSCS_PIN_ROT_INV 3
`define DSCS_PIN_REV_START 4
`define DSCS_PIN_UP 5
`define DSCS_PIN_DOWN 6
`define DSCS_PIN_FSEL_LSB 7
`define DSCS_PIN_FSEL_MSB 8
`define DSCS_PIN_SOURCE_SEL 9
`define DSCS_PIN_EMERG_SEL 10
`define DSCS_PIN_COUNT 11

// Run states
`define DSCS_ST_IDLE 2'h0
`define DSCS_ST_RUN 2'h1
`define DSCS_ST_STOP 2'h2
`define DSCS_ST_LOCKED 2'h3

// Reset values
`define DSCS_FREQ_RESET 16'h0000
`define DSCS_STEP_RESET 16'h0001

// Keypad step rate: 10 ms between up/down steps at 100 MHz
`define DSCS_STEP_PERIOD_NS 10000000
`define DSCS_CLK_PERIOD_NS 10
`define DSCS_STEP_CYCLES (`DSCS_STEP_PERIOD_NS / `DSCS_CLK_PERIOD_NS)

`endif

// [hw/dscs_sync.v]
`timescale 1ns/1ps
`default_nettype none

module dscs_sync #(
	parameter WIDTH = 1
) (
	input wire ref_clk,
	input wire nrst,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] stage1;
reg [WIDTH-1:0] stage2;

genvar i;
generate
	for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
		// First stage feeds only the second one
		always @(posedge ref_clk or negedge nrst) begin
			if (!nrst) begin
				stage1[i] <= 1'b0;
				stage2[i] <= 1'b0;
			end else begin
				stage1[i] <= async_in[i];
				stage2[i] <= stage1[i];
			end
		end
	end
endgenerate

assign sync_out = stage2;

endmodule // dscs_sync

`default_nettype wire

// [hw/dscs_top.v]
// Notes on behaviour
// - Fixed-versus-max selector low uses picked fixed frequency, high uses maximum speed.
// - Second-versus-fourth selector: low gives fixed two, high gives fixed four.
// - Fourth-versus-analog selector: low gives fixed four, high gives analog one.
// - Fourth-versus-bus selector: low gives fixed four, high gives bus setpoint.
// - Fourth-versus-digital selector: low gives fixed four, high gives keypad setpoint.
// - Fourth-versus-second selector: low gives fixed four, high gives fixed two.
// - Fourth-versus-regulator selector: low gives fixed four, high gives regulator setpoint.
// - Emergency selector low ignores drive faults and keeps running; high is normal.
// - Regulator-versus-analog selector: low gives regulator, high gives analog one.
// - Regulator-versus-first selector: low gives regulator, high gives fixed one.
// - Quick-stop enable must stay high to run; low stops at once on quick ramp.
// - Run input high accelerates the motor on the selected ramp.
// - Run input low stops the motor using the configured stop mode.
// - After a completed stop the drive locks and never restarts by itself.
// - With two directions, direction comes from direction and invert inputs.
// - Keypad setpoint: normal start keeps last direction, reverse start runs opposite.
// - Increment raises setpoint only in control modes 1 or 2, paired with decrement.
// - Fixed select bits msb,lsb: 00 one, 01 two, 10 three, 11 four.
`include "dscs_map.vh"
`timescale 1ns/1ps
`default_nettype none

module dscs_top #(
	parameter SP_W = 16,
	parameter STEP_CYCLES = `DSCS_STEP_CYCLES
) (
	input wire ref_clk,
	input wire nrst,
	input wire [`DSCS_PIN_COUNT-1:0] term_in,
	input wire [SP_W-1:0] analog_in1_setpoint,
	input wire [SP_W-1:0] bus_setpoint,
	input wire [SP_W-1:0] regulator_setpoint,
	input wire drive_fault,
	input wire speed_zero,
	input wire [7:0] addr,
	input wire [31:0] wr_data,
	input wire wr_en,
	input wire rd_en,
	output reg [31:0] rd_data,
	output reg [SP_W-1:0] setpoint,
	output reg run_enable,
	output reg quick_ramp,
	output reg [1:0] stop_mode,
	output reg reverse,
	output reg emergency_run,
	output reg fault_trip,
	output reg drive_locked
);

////////////////////////////////////////////////////////////////////////////////
// Terminal synchronisation

wire [`DSCS_PIN_COUNT-1:0] pin;

dscs_sync #(
	.WIDTH(`DSCS_PIN_COUNT)
) u_sync (
	.ref_clk(ref_clk),
	.nrst(nrst),
	.async_in(term_in),
	.sync_out(pin)
);

wire run_lvl = pin[`DSCS_PIN_RUN];
wire qs_en = pin[`DSCS_PIN_QSTOP_EN];
wire dir_lvl = pin[`DSCS_PIN_DIR];
wire rotation_invert = pin[`DSCS_PIN_ROT_INV];
wire reverse_start_cmd = pin[`DSCS_PIN_REV_START];
wire up_lvl = pin[`DSCS_PIN_UP];
wire down_lvl = pin[`DSCS_PIN_DOWN];
wire fixed_select_lsb = pin[`DSCS_PIN_FSEL_LSB];
wire fixed_select_msb = pin[`DSCS_PIN_FSEL_MSB];
wire source_sel = pin[`DSCS_PIN_SOURCE_SEL];
wire emergency_run_select = pin[`DSCS_PIN_EMERG_SEL];

////////////////////////////////////////////////////////////////////////////////
// Registers

reg [7:0] ctrl;
reg [SP_W-1:0] fixed_freq_one;
reg [SP_W-1:0] fixed_freq_two;
reg [SP_W-1:0] fixed_freq_three;
reg [SP_W-1:0] fixed_freq_four;
reg [SP_W-1:0] max_speed;
reg [SP_W-1:0] keypad_setpoint;
reg [SP_W-1:0] step_size;
reg [1:0] state;

wire [1:0] ctrl_mode = ctrl[`DSCS_CTRL_MODE_MSB:`DSCS_CTRL_MODE_LSB];
wire [3:0] sel_mode = ctrl[`DSCS_CTRL_SEL_MSB:`DSCS_CTRL_SEL_LSB];
wire digital_mode = (ctrl_mode == `DSCS_MODE_DIG_ONE) || (ctrl_mode == `DSCS_MODE_DIG_TWO);
wire wr_keypad = wr_en && (addr == `DSCS_REG_KEYPAD);

always @(posedge ref_clk or negedge nrst) begin
	if (!nrst) begin
		ctrl <= `DSCS_CTRL_RESET;
		fixed_freq_one <= `DSCS_FREQ_RESET;
		fixed_freq_two <= `DSCS_FREQ_RESET;
		fixed_freq_three <= `DSCS_FREQ_RESET;
		fixed_freq_four <= `DSCS_FREQ_RESET;
		max_speed <= `DSCS_FREQ_RESET;
		step_size <= `DSCS_STEP_RESET;
	end else if (wr_en) begin
		case (addr)
			`DSCS_REG_CTRL: ctrl <= wr_data[7:0];
			`DSCS_REG_FIX1: fixed_freq_one <= wr_data[SP_W-1:0];
			`DSCS_REG_FIX2: fixed_freq_two <= wr_data[SP_W-1:0];
			`DSCS_REG_FIX3: fixed_freq_three <= wr_data[SP_W-1:0];
			`DSCS_REG_FIX4: fixed_freq_four <= wr_data[SP_W-1:0];
			`DSCS_REG_FMAX: max_speed <= wr_data[SP_W-1:0];
			`DSCS_REG_STEP: step_size <= wr_data[SP_W-1:0];
			default: ;
		endcase
	end
end

// Unmapped addresses read as zero; data stands one cycle after the strobe
always @(posedge ref_clk or negedge nrst) begin
	if (!nrst) begin
		rd_data <= 32'h00000000;
	end else if (rd_en) begin
		case (addr)
			`DSCS_REG_CTRL: rd_data <= {24'h000000, ctrl};
			`DSCS_REG_FIX1: rd_data <= {{(32-SP_W){1'b0}}, fixed_freq_one};
			`DSCS_REG_FIX2: rd_data <= {{(32-SP_W){1'b0}}, fixed_freq_two};
			`DSCS_REG_FIX3: rd_data <= {{(32-SP_W){1'b0}}, fixed_freq_three};
			`DSCS_REG_FIX4: rd_data <= {{(32-SP_W){1'b0}}, fixed_freq_four};
			`DSCS_REG_FMAX: rd_data <= {{(32-SP_W){1'b0}}, max_speed};
			`DSCS_REG_KEYPAD: rd_data <= {{(32-SP_W){1'b0}}, keypad_setpoint};
			`DSCS_REG_STEP: rd_data <= {{(32-SP_W){1'b0}}, step_size};
			`DSCS_REG_SETPOINT: rd_data <= {{(32-SP_W){1'b0}}, setpoint};
			`DSCS_REG_PINS: rd_data <= {{(32-`DSCS_PIN_COUNT){1'b0}}, pin};
			`DSCS_REG_STATUS: rd_data <= {24'h000000, fault_trip, emergency_run, reverse, quick_ramp,
				drive_locked, run_enable, state};
			default: rd_data <= 32'h00000000;
		endcase
	end else begin
		rd_data <= 32'h00000000;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Keypad setpoint with up/down stepping

reg [31:0] step_cnt;
wire step_tick = (step_cnt == 32'h00000000);

always @(posedge ref_clk or negedge nrst) begin
	if (!nrst) begin
		step_cnt <= 32'h00000000;
	end else if (step_tick) begin
		step_cnt <= STEP_CYCLES - 1;
	end else begin
		step_cnt <= step_cnt - 32'h00000001;
	end
end

wire [SP_W:0] up_sum = {1'b0, keypad_setpoint} + {1'b0, step_size};
reg [SP_W-1:0] next_keypad;

// Both held together cancel; steps saturate at zero and at maximum speed
always @* begin
	next_keypad = keypad_setpoint;
	if (digital_mode && step_tick && (up_lvl != down_lvl)) begin
		if (up_lvl) begin
			if (up_sum > {1'b0, max_speed})
				next_keypad = max_speed;
			else
				next_keypad = up_sum[SP_W-1:0];
		end else begin
			if (keypad_setpoint > step_size)
				next_keypad = keypad_setpoint - step_size;
			else
				next_keypad = {SP_W{1'b0}};
		end
	end
end

always @(posedge ref_clk or negedge nrst) begin
	if (!nrst) begin
		keypad_setpoint <= `DSCS_FREQ_RESET;
	end else if (wr_keypad) begin
		keypad_setpoint <= wr_data[SP_W-1:0];
	end else begin
		keypad_setpoint <= next_keypad;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Setpoint source selection

reg [SP_W-1:0] fixed_pick;
reg [SP_W-1:0] next_setpoint;

always @* begin
	case ({fixed_select_msb, fixed_select_lsb})
		2'h0: fixed_pick = fixed_freq_one;
		2'h1: fixed_pick = fixed_freq_two;
		2'h2: fixed_pick = fixed_freq_three;
		default: fixed_pick = fixed_freq_four;
	endcase
end

always @* begin
	case (sel_mode)
		`DSCS_SEL_FIX_MAX: next_setpoint = source_sel ? max_speed : fixed_pick;
		`DSCS_SEL_F2_F4: next_setpoint = source_sel ? fixed_freq_four : fixed_freq_two;
		`DSCS_SEL_F4_AI1: next_setpoint = source_sel ? analog_in1_setpoint : fixed_freq_four;
		`DSCS_SEL_F4_BUS: next_setpoint = source_sel ? bus_setpoint : fixed_freq_four;
		`DSCS_SEL_F4_DIG: next_setpoint = source_sel ? keypad_setpoint : fixed_freq_four;
		`DSCS_SEL_F4_F2: next_setpoint = source_sel ? fixed_freq_two : fixed_freq_four;
		`DSCS_SEL_F4_REG: next_setpoint = source_sel ? regulator_setpoint : fixed_freq_four;
		`DSCS_SEL_REG_AI1: next_setpoint = source_sel ? analog_in1_setpoint : regulator_setpoint;
		`DSCS_SEL_REG_F1: next_setpoint = source_sel ? fixed_freq_one : regulator_setpoint;
		default: next_setpoint = fixed_pick;
	endcase
end

// Registered so a changed selection shows one cycle after it is sampled
always @(posedge ref_clk or negedge nrst) begin
	if (!nrst) begin
		setpoint <= `DSCS_FREQ_RESET;
	end else begin
		setpoint <= next_setpoint;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Run, stop and lock sequencing

reg run_prev;
reg rev_prev;
reg [1:0] primed;
reg last_dir;
reg [1:0] next_state;

wire start_req = run_lvl || reverse_start_cmd;
wire run_rise = run_lvl && !run_prev;
wire rev_rise = reverse_start_cmd && !rev_prev;
wire rev_start = rev_rise && !run_rise;
// Fire mode masks faults so the drive keeps turning until it cannot
wire fault_now = drive_fault && emergency_run_select;

always @* begin
	next_state = state;
	case (state)
		`DSCS_ST_IDLE: begin
			if (fault_now)
				next_state = `DSCS_ST_LOCKED;
			else if (start_req && qs_en)
				next_state = `DSCS_ST_RUN;
		end
		`DSCS_ST_RUN: begin
			if (fault_now)
				next_state = `DSCS_ST_LOCKED;
			else if (!qs_en)
				next_state = `DSCS_ST_STOP;
			else if (!start_req)
				next_state = `DSCS_ST_STOP;
		end
		`DSCS_ST_STOP: begin
			if (fault_now || speed_zero)
				next_state = `DSCS_ST_LOCKED;
		end
		`DSCS_ST_LOCKED: begin
			// A held start never restarts; the command must drop first
			if (!start_req && !fault_now)
				next_state = `DSCS_ST_IDLE;
		end
		default: next_state = `DSCS_ST_IDLE;
	endcase
end

always @(posedge ref_clk or negedge nrst) begin
	if (!nrst) begin
		state <= `DSCS_ST_IDLE;
		run_prev <= 1'b0;
		rev_prev <= 1'b0;
		primed <= 2'h0;
	end else begin
		state <= next_state;
		run_prev <= run_lvl;
		rev_prev <= reverse_start_cmd;
		primed <= {primed[0], 1'b1};
	end
end

// Keypad modes remember the direction of the last start
always @(posedge ref_clk or negedge nrst) begin
	if (!nrst) begin
		last_dir <= 1'b0;
	end else if (state == `DSCS_ST_IDLE && next_state == `DSCS_ST_RUN) begin
		if (rev_start)
			last_dir <= ~last_dir;
	end
end

reg next_reverse;

always @* begin
	case (ctrl_mode)
		`DSCS_MODE_DIG_ONE, `DSCS_MODE_DIG_TWO: next_reverse = last_dir ^ rev_start;
		default: next_reverse = dir_lvl ^ rotation_invert;
	endcase
end

always @(posedge ref_clk or negedge nrst) begin
	if (!nrst) begin
		run_enable <= 1'b0;
		quick_ramp <= 1'b0;
		stop_mode <= 2'h0;
		reverse <= 1'b0;
		emergency_run <= 1'b0;
		fault_trip <= 1'b0;
		drive_locked <= 1'b0;
	end else begin
		run_enable <= (next_state == `DSCS_ST_RUN);
		if (state == `DSCS_ST_RUN && !qs_en)
			quick_ramp <= 1'b1;
		else if (next_state != `DSCS_ST_STOP)
			quick_ramp <= 1'b0;
		stop_mode <= ctrl[`DSCS_CTRL_STOP_MSB:`DSCS_CTRL_STOP_LSB];
		// Direction is frozen while turning to avoid a reversal under load, except in terminal mode where it follows the pins
		if (next_state == `DSCS_ST_RUN && state == `DSCS_ST_IDLE)
			reverse <= next_reverse;
		else if (state == `DSCS_ST_RUN && ctrl_mode == `DSCS_MODE_TERMINAL)
			reverse <= next_reverse;
		// Synchroniser resets low, which would read as fire mode until the pins arrive
		emergency_run <= primed[1] && !emergency_run_select;
		fault_trip <= fault_now;
		drive_locked <= (next_state == `DSCS_ST_LOCKED);
	end
end

endmodule // dscs_top

`default_nettype wire

// [test/dscs_checker.sv]
`include "dscs_map.vh"
`timescale 1ns/1ps
`default_nettype none

module dscs_checker (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [`DSCS_PIN_COUNT-1:0] term_in,
	input wire logic drive_fault,
	input wire logic speed_zero,
	input wire logic [7:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic run_enable,
	input wire logic quick_ramp,
	input wire logic [1:0] stop_mode,
	input wire logic emergency_run,
	input wire logic fault_trip,
	input wire logic drive_locked
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	logic [2:0] age;
	logic ctrl_wr;
	assign ctrl_wr = wr_en && addr == `DSCS_REG_CTRL;
	// Pin levels from before release never reach the outputs, so wait out the pipeline
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			age <= 3'h0;
		else if (age != 3'h4)
			age <= age + 3'h1;
	end
	sequence qs_held;
		(!term_in[`DSCS_PIN_QSTOP_EN] && term_in[`DSCS_PIN_RUN] && !drive_fault && !speed_zero) [*3];
	endsequence
	sequence run_dropped;
		(!term_in[`DSCS_PIN_RUN] && !term_in[`DSCS_PIN_REV_START]) [*3];
	endsequence
	sequence ctrl_written;
		ctrl_wr ##1 !ctrl_wr ##1 !ctrl_wr;
	endsequence
	AST_EMERG_LEVEL: assert property (age == 3'h4 |-> emergency_run == !$past(term_in[`DSCS_PIN_EMERG_SEL], 3))
		else $error("emergency output does not follow its select pin");
	AST_FAULT_MASKED: assert property (emergency_run ##1 emergency_run |-> !fault_trip)
		else $error("fault trip raised in emergency running");
	AST_FAULT_TRIPS: assert property (age == 3'h4 && drive_fault && !emergency_run ##1 !emergency_run |-> fault_trip)
		else $error("fault not tripped in normal operation");
	AST_QUICK_STOP: assert property (run_enable ##0 qs_held |=> !run_enable && quick_ramp)
		else $error("no quick stop after enable removed");
	AST_RUN_STOP: assert property (run_enable ##0 run_dropped |=> !run_enable)
		else $error("still running after run input low");
	AST_STOP_MODE: assert property (ctrl_written |-> stop_mode == $past(wr_data[`DSCS_CTRL_STOP_MSB:`DSCS_CTRL_STOP_LSB], 2))
		else $error("stop mode output differs from written value");
	AST_LOCK_HOLD: assert property (drive_locked |=> !run_enable)
		else $error("restart directly out of the locked state");
	AST_STOP_DONE: assert property (quick_ramp && speed_zero |=> drive_locked)
		else $error("completed stop did not lock");
endmodule // dscs_checker

bind dscs_top dscs_checker dscs_checker_i (
	.ref_clk(ref_clk),
	.nrst(nrst),
	.term_in(term_in),
	.drive_fault(drive_fault),
	.speed_zero(speed_zero),
	.addr(addr),
	.wr_data(wr_data),
	.wr_en(wr_en),
	.run_enable(run_enable),
	.quick_ramp(quick_ramp),
	.stop_mode(stop_mode),
	.emergency_run(emergency_run),
	.fault_trip(fault_trip),
	.drive_locked(drive_locked)
);
`default_nettype wire

// [test/dscs_switches.sv]
`include "dscs_map.vh"
`timescale 1ns/1ps
`default_nettype none

module dscs_switches (
	input wire logic ref_clk,
	output logic [`DSCS_PIN_COUNT-1:0] term_in
);
	initial begin
		term_in = '0;
		term_in[`DSCS_PIN_QSTOP_EN] = 1'b1;
		term_in[`DSCS_PIN_EMERG_SEL] = 1'b1;
	end
	task automatic put(input int idx, input logic lvl);
		@(posedge ref_clk);
		term_in[idx] <= lvl;
	endtask
endmodule // dscs_switches
`default_nettype wire

// [test/dscs_top_test.sv]
`include "dscs_map.vh"
`timescale 1ns/1ps
`default_nettype none

module dscs_top_test;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	wire [`DSCS_PIN_COUNT-1:0] term_in;
	logic [15:0] ai, bus, rg, kp, setpoint;
	logic drive_fault, speed_zero, wr_en, rd_en, rd_pend;
	logic [7:0] addr;
	logic [31:0] wr_data, rd_data, exp_q[$];
	logic run_enable, quick_ramp, reverse, emergency_run, fault_trip, drive_locked;
	logic [1:0] stop_mode;
	logic [15:0] f [0:4];
	string nm_q[$];
	int fail_count = 0;
	int num_checks = 0;

	always #5 ref_clk = ~ref_clk;

	dscs_switches dscs_switches_i (.ref_clk(ref_clk), .term_in(term_in));
	dscs_top #(.STEP_CYCLES(4)) dscs_top_i (.ref_clk(ref_clk), .nrst(nrst), .term_in(term_in),
		.analog_in1_setpoint(ai), .bus_setpoint(bus), .regulator_setpoint(rg), .drive_fault(drive_fault),
		.speed_zero(speed_zero), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
		.rd_data(rd_data), .setpoint(setpoint), .run_enable(run_enable), .quick_ramp(quick_ramp),
		.stop_mode(stop_mode), .reverse(reverse), .emergency_run(emergency_run), .fault_trip(fault_trip),
		.drive_locked(drive_locked));

	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Read data stands only in the cycle after the strobe
	always @(posedge ref_clk) begin
		if (rd_pend)
			chk(nm_q.pop_front(), exp_q.pop_front(), rd_data);
		rd_pend <= rd_en;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		nm_q.push_back(nm);
		@(posedge ref_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge ref_clk);
		rd_en <= 1'b0;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic pin(input int i, input logic v, input int n);
		dscs_switches_i.put(i, v);
		settle(n);
	endtask
	task automatic pulse_zero();
		@(posedge ref_clk);
		speed_zero <= 1'b1;
		settle(1);
		chk("locked", 1, drive_locked);
		@(posedge ref_clk);
		speed_zero <= 1'b0;
	endtask
	function automatic logic [15:0] sp_exp(input int s, input logic l, input int fs);
		case (s)
			0: return l ? f[4] : f[fs];
			1: return l ? f[3] : f[1];
			2: return l ? ai : f[3];
			3: return l ? bus : f[3];
			4: return l ? kp : f[3];
			5: return l ? f[1] : f[3];
			6: return l ? rg : f[3];
			7: return l ? ai : rg;
			default: return l ? f[0] : rg;
		endcase
	endfunction
	task tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		fail_count++;
		tally_and_finish();
	end
	initial begin
		{ai, bus, rg, drive_fault, speed_zero, wr_en, rd_en, rd_pend, addr, wr_data} = '0;
		void'($urandom(32'h542A));
		repeat (12) @(posedge ref_clk);
		nrst <= 1'b1;
		rd("ctrl", `DSCS_REG_CTRL, 32'h0);
		rd("unmapped", 8'hFC, 32'h0);
		for (int i = 0; i < 5; i++) begin
			f[i] = 16'($urandom);
			wr(8'(`DSCS_REG_FIX1 + 4 * i), {16'h0000, f[i]});
		end
		kp = 16'($urandom);
		wr(`DSCS_REG_KEYPAD, {16'h0000, kp});
		for (int s = 0; s < 9; s++) begin
			ai <= 16'($urandom);
			bus <= 16'($urandom);
			rg <= 16'($urandom);
			wr(`DSCS_REG_CTRL, 32'(s << 2));
			for (int l = 0; l < 2; l++) begin
				for (int fs = 0; fs < 4; fs++) begin
					dscs_switches_i.put(`DSCS_PIN_FSEL_LSB, fs[0]);
					dscs_switches_i.put(`DSCS_PIN_FSEL_MSB, fs[1]);
					pin(`DSCS_PIN_SOURCE_SEL, l[0], 4);
					chk("setpoint", sp_exp(s, l[0], fs), setpoint);
				end
			end
			rd("setpoint reg", `DSCS_REG_SETPOINT, {16'h0000, sp_exp(s, 1'b1, 3)});
		end
		wr(`DSCS_REG_CTRL, 32'h04);
		pin(`DSCS_PIN_SOURCE_SEL, 1'b0, 4);
		pin(`DSCS_PIN_SOURCE_SEL, 1'b1, 2);
		chk("late setpoint", f[1], setpoint);
		settle(1);
		chk("next setpoint", f[3], setpoint);
		wr(`DSCS_REG_CTRL, 32'h00);
		pin(`DSCS_PIN_RUN, 1'b1, 4);
		chk("run", 1, run_enable);
		pin(`DSCS_PIN_DIR, 1'b1, 4);
		chk("reverse", 1, reverse);
		pin(`DSCS_PIN_ROT_INV, 1'b1, 4);
		chk("reverse", 0, reverse);
		pin(`DSCS_PIN_QSTOP_EN, 1'b0, 4);
		chk("quick ramp", 1, quick_ramp);
		pulse_zero();
		pin(`DSCS_PIN_QSTOP_EN, 1'b1, 6);
		chk("no restart", 0, run_enable);
		pin(`DSCS_PIN_RUN, 1'b0, 4);
		pin(`DSCS_PIN_RUN, 1'b1, 4);
		wr(`DSCS_REG_CTRL, 32'h80);
		settle(2);
		chk("stop mode", 2, stop_mode);
		pin(`DSCS_PIN_RUN, 1'b0, 4);
		chk("stopped", 0, run_enable);
		pulse_zero();
		pin(`DSCS_PIN_RUN, 1'b1, 6);
		pin(`DSCS_PIN_EMERG_SEL, 1'b0, 4);
		@(posedge ref_clk);
		drive_fault <= 1'b1;
		settle(3);
		chk("fault ignored", 1, run_enable && !fault_trip && emergency_run);
		pin(`DSCS_PIN_EMERG_SEL, 1'b1, 5);
		chk("fault lock", 1, fault_trip && drive_locked);
		@(posedge ref_clk);
		drive_fault <= 1'b0;
		pin(`DSCS_PIN_RUN, 1'b0, 4);
		wr(`DSCS_REG_FMAX, 32'hFFFF);
		// Modes 3, 0, 1, 2 in turn so the run ends in a keypad mode
		for (int m = 0; m < 4; m++) begin
			wr(`DSCS_REG_KEYPAD, 32'h0010);
			wr(`DSCS_REG_CTRL, 32'(16 + (m + 3) % 4));
			pin(`DSCS_PIN_UP, 1'b1, 40);
			pin(`DSCS_PIN_UP, 1'b0, 4);
			chk("keypad step", m >= 2, setpoint > 16'h0010 && setpoint < 16'h001C);
		end
		pin(`DSCS_PIN_DOWN, 1'b1, 40);
		pin(`DSCS_PIN_DOWN, 1'b0, 4);
		chk("keypad down", 1, setpoint >= 16'h000F && setpoint <= 16'h0011);
		pin(`DSCS_PIN_REV_START, 1'b1, 4);
		chk("reverse start", 1, run_enable && reverse);
		pin(`DSCS_PIN_REV_START, 1'b0, 4);
		pulse_zero();
		pin(`DSCS_PIN_RUN, 1'b1, 6);
		chk("last direction", 1, run_enable && reverse);
		tally_and_finish();
	end
endmodule // dscs_top_test
`default_nettype wire
